// ===== src/pmwc_pkg.sv
/*
  Constants for the power mode and wakeup control block: register indices,
  field positions, reset values and the encodings of the power modes.
  Assumes a bus slave that places register index i at byte address 4*i.
*/
package pmwc_pkg;

   // Register indices; byte address is four times the index.
   localparam logic [7:0] IDX_SYS_CTRL_ONE = 8'hF0;
   localparam logic [7:0] IDX_POWER_MODE_CONTROL_TWO = 8'hF1;
   localparam logic [7:0] IDX_EDGE_SELECT = 8'hF2;
   localparam logic [7:0] IDX_INT_ENABLE = 8'hF3;
   localparam logic [7:0] IDX_INT_REQUEST = 8'hF4;
   localparam logic [7:0] IDX_WAKEUP_ENABLE = 8'hF5;
   localparam logic [7:0] IDX_WAKEUP_REQUEST_FLAGS = 8'hF9;
   localparam logic [7:0] IDX_CLOCK_STOP_ONE = 8'hFA;
   localparam logic [7:0] IDX_CLOCK_STOP_TWO = 8'hFB;

   // Field positions.
   localparam int SC1_STANDBY_BIT = 7;
   localparam int SC1_LOW_SPEED_BIT = 3;
   localparam logic [7:0] SC1_STORED_MASK = 8'hFB;
   localparam logic [7:0] SC1_RESET = 8'h07;
   localparam int PMC2_NOISE_BIT = 4;
   localparam int PMC2_DIRECT_BIT = 3;
   localparam int PMC2_MEDIUM_BIT = 2;
   localparam int PMC2_SUB_HI_BIT = 1;
   localparam int PMC2_SUB_LO_BIT = 0;
   localparam logic [7:0] PMC2_STORED_MASK = 8'h1F;
   localparam logic [7:0] PMC2_RESET = 8'hF0;
   localparam int EDGE_EXTERNAL_INTERRUPT_FOUR_BIT = 4;
   localparam int INTEN_TIMER_A_BIT = 0;
   localparam int INTEN_DIRECT_BIT = 1;
   localparam int IRR_TIMER_A_BIT = 0;
   localparam int IRR_DIRECT_BIT = 1;
   localparam int CKS1_SECONDARY_SERIAL_BIT = 0;
   localparam int CKS1_DECODER_SERIAL_BIT = 1;
   localparam logic [7:0] CKS1_RESET = 8'hFF;
   localparam int CKS2_WATCHDOG_BIT = 2;
   localparam logic [7:0] CKS2_RESET = 8'hFF;

   // Divide ratios published to the clock generator.
   localparam logic [7:0] NOISE_DIV_SLOW = 8'h10;
   localparam logic [7:0] NOISE_DIV_FAST = 8'h04;
   localparam logic [3:0] SUB_DIV_EIGHT = 4'h8;
   localparam logic [3:0] SUB_DIV_FOUR = 4'h4;
   localparam logic [3:0] SUB_DIV_TWO = 4'h2;

   typedef enum logic [2:0] {
      PMWC_HIGH_SPEED = 3'b000,
      PMWC_MEDIUM_SPEED = 3'b001,
      PMWC_SUBACTIVE = 3'b010,
      PMWC_SLEEP = 3'b011,
      PMWC_SUBSLEEP = 3'b100,
      PMWC_STANDBY = 3'b101,
      PMWC_WATCH = 3'b110
   } pmwc_mode_type;

endpackage

// ===== src/pmwc_top.sv
/*
  Power mode and wakeup control: low-power mode selection on a sleep
  instruction, direct speed transitions, clock divider and edge selects,
  interrupt enables and request flags, wakeup pin flags and module standby.
  Assumes an Avalon-MM master on clk_sys, a one-cycle sleep pulse from the
  CPU and a one-cycle timer A overflow pulse; wakeup pins are asynchronous.
*/
// Function
// - Standby select 0: sleep goes active to sleep, subactive to subsleep.
// - Standby select 1: sleep goes active to standby or watch, sub to watch.
// - Medium-speed select 0 runs active at high speed, 1 at medium speed.
// - Direct transfer 0: sleep enters standby, watch, sleep or subsleep.
// - Direct from high speed: to medium, or to subactive per the bits.
// - Direct from medium speed: to high, or to subactive per the bits.
// - Direct from subactive to high or medium speed per medium select.
// - Noise filter samples at oscillator over 16 for 0, over 4 for 1.
// - Edge select 0 detects falling edges, 1 rising, on external interrupt four only.
// - Timer A enable blocks requests at 0 and passes them at 1.
// - Direct transition enable blocks requests at 0, passes them at 1.
// - Timer A flag sets on counter wrap; writing 0 clears it.
// - Direct transition flag sets on a direct transition; 0 clears it.
// - Each wakeup flag sets on an edge at an enabled pin; 0 clears it.
// - Secondary serial stop bit 0 puts the unit in standby, 1 releases.
// - Decoder serial stop bit 0 puts the unit in standby, 1 releases.
// - Watchdog stop bit 0 puts the watchdog in standby; resets to 1.
// - Low-speed select 0 runs the CPU on system clock, 1 on subclock.
module pmwc_top
   import pmwc_pkg::*;
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst,
   // Avalon-MM register slave.
   input wire logic [9:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // CPU and timer events.
   input wire logic sleep_exec,
   input wire logic wake_request,
   input wire logic timer_a_overflow,
   input wire logic timer_a_clock_source_bit,
   // Wakeup pins.
   input wire logic [7:0] wakeup_pin,
   // Mode and clock control outputs.
   output logic [2:0] power_mode,
   output logic cpu_on_subclock,
   output logic [3:0] subactive_divide,
   output logic [7:0] noise_filter_divide,
   output logic external_interrupt_four_rising_edge,
   // Interrupt requests to the CPU.
   output logic timer_a_irq,
   output logic direct_transition_irq,
   output logic wakeup_irq,
   // Module standby controls.
   output logic secondary_serial_standby,
   output logic decoder_serial_standby,
   output logic watchdog_standby
);

   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
      pmwc_mode_type mode;
      logic [7:0] sys_ctrl_one;
      logic [7:0] power_mode_control_two;
      logic [7:0] edge_select;
      logic [7:0] int_enable;
      logic [7:0] int_request;
      logic [7:0] wakeup_enable;
      logic [7:0] wakeup_request_flags;
      logic [7:0] clock_stop_one;
      logic [7:0] clock_stop_two;
      logic [7:0] pin_meta;
      logic [7:0] pin_sync;
      logic [7:0] pin_last;
      logic [3:0] sub_div;
      logic [7:0] noise_div;
      logic timer_irq;
      logic direct_irq;
      logic wake_irq;
      logic secondary_standby;
      logic decoder_standby;
      logic watchdog_idle;
   } pmwc_state_type;

   pmwc_state_type state;
   pmwc_state_type next_state;

   logic [7:0] index;
   logic mapped;
   logic [7:0] read_value;
   logic do_write;
   logic [7:0] wdata;
   logic software_standby_select;
   logic low_speed_select;
   logic medium_speed_select;
   logic direct_transfer_select;
   logic [7:0] pin_edge;
   logic wake_any;
   logic [7:0] wake_set;

   assign index = avs_address[9:2];
   assign wdata = avs_writedata[7:0];
   assign software_standby_select = state.sys_ctrl_one[SC1_STANDBY_BIT];
   assign low_speed_select = state.sys_ctrl_one[SC1_LOW_SPEED_BIT];
   assign medium_speed_select = state.power_mode_control_two[PMC2_MEDIUM_BIT];
   assign direct_transfer_select = state.power_mode_control_two[PMC2_DIRECT_BIT];

   // Address decode and read multiplexer.
   always_comb begin
      mapped = 1'b1;
      read_value = 8'h00;
      unique case (index)
         IDX_SYS_CTRL_ONE: begin
            read_value = state.sys_ctrl_one;
         end
         IDX_POWER_MODE_CONTROL_TWO: begin
            read_value = state.power_mode_control_two;
         end
         IDX_EDGE_SELECT: begin
            read_value = state.edge_select;
         end
         IDX_INT_ENABLE: begin
            read_value = state.int_enable;
         end
         IDX_INT_REQUEST: begin
            read_value = state.int_request;
         end
         IDX_WAKEUP_ENABLE: begin
            read_value = state.wakeup_enable;
         end
         IDX_WAKEUP_REQUEST_FLAGS: begin
            read_value = state.wakeup_request_flags;
         end
         IDX_CLOCK_STOP_ONE: begin
            read_value = state.clock_stop_one;
         end
         IDX_CLOCK_STOP_TWO: begin
            read_value = state.clock_stop_two;
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   // One wait cycle per access keeps read data coming from a flip-flop.
   assign avs_waitrequest = (avs_read | avs_write) & ~state.ack;
   assign do_write = avs_write & state.ack & mapped & avs_byteenable[0];

   // Edges are taken only after both synchroniser stages.
   assign pin_edge = state.pin_sync ^ state.pin_last;
   assign wake_any = wake_request | (|state.wakeup_request_flags);

   // Each pin has its own set term; a pin that is not a wakeup input may
   // toggle freely without ever raising its flag.
   for (genvar i = 0; i < $bits(wake_set); i++) begin : g_wake_pin
      assign wake_set[i] = pin_edge[i] & state.wakeup_enable[i];
   end

   always_comb begin
      next_state = state;
      next_state.ack = (avs_read | avs_write) & ~state.ack;
      if ((avs_read | avs_write) & ~state.ack) begin
         next_state.rdata = {24'h000000, read_value};
      end
      next_state.pin_meta = wakeup_pin;
      next_state.pin_sync = state.pin_meta;
      next_state.pin_last = state.pin_sync;

      // Register writes; unused bits keep their initial value.
      if (do_write) begin
         unique case (index)
            IDX_SYS_CTRL_ONE: begin
               next_state.sys_ctrl_one = (wdata & SC1_STORED_MASK)
                  | (SC1_RESET & ~SC1_STORED_MASK);
            end
            IDX_POWER_MODE_CONTROL_TWO: begin
               next_state.power_mode_control_two =
                  (wdata & PMC2_STORED_MASK)
                  | (PMC2_RESET & ~PMC2_STORED_MASK);
            end
            IDX_EDGE_SELECT: begin
               next_state.edge_select = 8'h00;
               next_state.edge_select[EDGE_EXTERNAL_INTERRUPT_FOUR_BIT] =
                  wdata[EDGE_EXTERNAL_INTERRUPT_FOUR_BIT];
            end
            IDX_INT_ENABLE: begin
               next_state.int_enable = 8'h00;
               next_state.int_enable[INTEN_TIMER_A_BIT] =
                  wdata[INTEN_TIMER_A_BIT];
               next_state.int_enable[INTEN_DIRECT_BIT] =
                  wdata[INTEN_DIRECT_BIT];
            end
            IDX_INT_REQUEST: begin
               next_state.int_request = state.int_request & wdata;
            end
            IDX_WAKEUP_ENABLE: begin
               next_state.wakeup_enable = wdata;
            end
            IDX_WAKEUP_REQUEST_FLAGS: begin
               next_state.wakeup_request_flags =
                  state.wakeup_request_flags & wdata;
            end
            IDX_CLOCK_STOP_ONE: begin
               next_state.clock_stop_one = CKS1_RESET;
               next_state.clock_stop_one[CKS1_SECONDARY_SERIAL_BIT] =
                  wdata[CKS1_SECONDARY_SERIAL_BIT];
               next_state.clock_stop_one[CKS1_DECODER_SERIAL_BIT] =
                  wdata[CKS1_DECODER_SERIAL_BIT];
            end
            IDX_CLOCK_STOP_TWO: begin
               next_state.clock_stop_two = CKS2_RESET;
               next_state.clock_stop_two[CKS2_WATCHDOG_BIT] =
                  wdata[CKS2_WATCHDOG_BIT];
            end
            default: begin
            end
         endcase
      end

      // Timer A wrap sets its flag; a set wins over a clear.
      if (timer_a_overflow) begin
         next_state.int_request[IRR_TIMER_A_BIT] = 1'b1;
      end

      // Wakeup flags; a set wins over a clear in the same cycle.
      next_state.wakeup_request_flags = next_state.wakeup_request_flags
         | wake_set;

      // Power mode sequencing on a sleep instruction or a wake event.
      unique case (state.mode)
         PMWC_HIGH_SPEED, PMWC_MEDIUM_SPEED: begin
            if (sleep_exec) begin
               if (direct_transfer_select && !software_standby_select && !low_speed_select &&
                   (medium_speed_select != (state.mode == PMWC_MEDIUM_SPEED))) begin
                  // Direct switch between the two active speeds.
                  next_state.mode = medium_speed_select ? PMWC_MEDIUM_SPEED
                     : PMWC_HIGH_SPEED;
                  next_state.int_request[IRR_DIRECT_BIT] = 1'b1;
               end else if (direct_transfer_select && software_standby_select && timer_a_clock_source_bit &&
                            low_speed_select) begin
                  next_state.mode = PMWC_SUBACTIVE;
                  next_state.int_request[IRR_DIRECT_BIT] = 1'b1;
               end else if (!software_standby_select) begin
                  next_state.mode = PMWC_SLEEP;
               end else if (timer_a_clock_source_bit) begin
                  // The watch clock keeps running only with timer A on it.
                  next_state.mode = PMWC_WATCH;
               end else begin
                  next_state.mode = PMWC_STANDBY;
               end
            end
         end
         PMWC_SUBACTIVE: begin
            if (sleep_exec) begin
               if (direct_transfer_select && software_standby_select && timer_a_clock_source_bit && !low_speed_select) begin
                  next_state.mode = medium_speed_select ? PMWC_MEDIUM_SPEED
                     : PMWC_HIGH_SPEED;
                  next_state.int_request[IRR_DIRECT_BIT] = 1'b1;
               end else if (!software_standby_select) begin
                  next_state.mode = PMWC_SUBSLEEP;
               end else begin
                  next_state.mode = PMWC_WATCH;
               end
            end
         end
         PMWC_SLEEP, PMWC_STANDBY: begin
            if (wake_any) begin
               next_state.mode = medium_speed_select ? PMWC_MEDIUM_SPEED
                  : PMWC_HIGH_SPEED;
            end
         end
         PMWC_SUBSLEEP: begin
            if (wake_any) begin
               next_state.mode = PMWC_SUBACTIVE;
            end
         end
         PMWC_WATCH: begin
            // Wake to the subclock or the main clock as low-speed says.
            if (wake_any) begin
               if (low_speed_select) begin
                  next_state.mode = PMWC_SUBACTIVE;
               end else begin
                  next_state.mode = medium_speed_select ? PMWC_MEDIUM_SPEED
                     : PMWC_HIGH_SPEED;
               end
            end
         end
         default: begin
            next_state.mode = PMWC_HIGH_SPEED;
         end
      endcase

      // Outputs are registered from the next register values, so each one
      // moves on the same edge as the bits that it is decoded from.
      if (next_state.power_mode_control_two[PMC2_SUB_HI_BIT]) begin
         next_state.sub_div = SUB_DIV_TWO;
      end else if (next_state.power_mode_control_two[PMC2_SUB_LO_BIT]) begin
         next_state.sub_div = SUB_DIV_FOUR;
      end else begin
         next_state.sub_div = SUB_DIV_EIGHT;
      end
      next_state.noise_div =
         next_state.power_mode_control_two[PMC2_NOISE_BIT] ? NOISE_DIV_FAST
         : NOISE_DIV_SLOW;
      next_state.timer_irq = next_state.int_request[IRR_TIMER_A_BIT]
         & next_state.int_enable[INTEN_TIMER_A_BIT];
      next_state.direct_irq = next_state.int_request[IRR_DIRECT_BIT]
         & next_state.int_enable[INTEN_DIRECT_BIT];
      next_state.wake_irq = |next_state.wakeup_request_flags;
      next_state.secondary_standby =
         ~next_state.clock_stop_one[CKS1_SECONDARY_SERIAL_BIT];
      next_state.decoder_standby =
         ~next_state.clock_stop_one[CKS1_DECODER_SERIAL_BIT];
      next_state.watchdog_idle =
         ~next_state.clock_stop_two[CKS2_WATCHDOG_BIT];
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state <= '{
            ack: 1'b0,
            rdata: 32'h00000000,
            mode: PMWC_HIGH_SPEED,
            sys_ctrl_one: SC1_RESET,
            power_mode_control_two: PMC2_RESET,
            edge_select: 8'h00,
            int_enable: 8'h00,
            int_request: 8'h00,
            wakeup_enable: 8'h00,
            wakeup_request_flags: 8'h00,
            clock_stop_one: CKS1_RESET,
            clock_stop_two: CKS2_RESET,
            pin_meta: 8'h00,
            pin_sync: 8'h00,
            pin_last: 8'h00,
            sub_div: SUB_DIV_EIGHT,
            noise_div: NOISE_DIV_FAST,
            timer_irq: 1'b0,
            direct_irq: 1'b0,
            wake_irq: 1'b0,
            secondary_standby: 1'b0,
            decoder_standby: 1'b0,
            watchdog_idle: 1'b0
         };
      end else begin
         state <= next_state;
      end
   end

   assign avs_readdata = state.rdata;
   assign power_mode = state.mode;
   assign cpu_on_subclock = low_speed_select;

   assign subactive_divide = state.sub_div;
   assign noise_filter_divide = state.noise_div;
   assign external_interrupt_four_rising_edge = state.edge_select[EDGE_EXTERNAL_INTERRUPT_FOUR_BIT];
   assign timer_a_irq = state.timer_irq;
   assign direct_transition_irq = state.direct_irq;
   assign wakeup_irq = state.wake_irq;
   assign secondary_serial_standby = state.secondary_standby;
   assign decoder_serial_standby = state.decoder_standby;
   assign watchdog_standby = state.watchdog_idle;

endmodule

// ===== tb/pmwc_chk.sv
/*
  Concurrent checks on the ports of the power mode and wakeup control block.
  Assumes requests are single Avalon-MM transfers with one wait cycle.
*/
module pmwc_chk
   import pmwc_pkg::*;
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst,
   // Register bus.
   input wire logic [9:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // Events and pins.
   input wire logic sleep_exec,
   input wire logic wake_request,
   input wire logic timer_a_overflow,
   input wire logic [7:0] wakeup_pin,
   // Outputs watched.
   input wire logic [2:0] power_mode,
   input wire logic [3:0] subactive_divide,
   input wire logic [7:0] noise_filter_divide,
   input wire logic watchdog_standby,
   input wire logic timer_a_irq,
   input wire logic direct_transition_irq,
   input wire logic wakeup_irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   logic low_power;
   logic mapped;
   assign low_power = power_mode inside {PMWC_SLEEP, PMWC_SUBSLEEP,
      PMWC_STANDBY, PMWC_WATCH};
   assign mapped = avs_address[9:2] inside {[8'hF0:8'hF5], [8'hF9:8'hFB]};
   chk_bus_one_wait: assert property (
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("Bus access took more than one wait cycle.");
   chk_unmapped_zero: assert property (
      avs_read && !avs_waitrequest && !mapped |-> avs_readdata == 32'h0)
      else $error("Unmapped read returned nonzero data.");
   chk_timer_irq_cause: assert property (
      $rose(timer_a_irq) |-> $past(timer_a_overflow) || $past(avs_write))
      else $error("Timer A request rose without overflow or write.");
   chk_direct_irq_cause: assert property (
      $rose(direct_transition_irq) |-> $past(sleep_exec) || $past(avs_write))
      else $error("Direct request rose without sleep or write.");
   chk_wake_pin_cause: assert property (
      $rose(wakeup_irq) |-> $past(wakeup_pin, 3) != $past(wakeup_pin, 4))
      else $error("Wakeup request rose without a pin edge.");
   chk_mode_cause: assert property (
      power_mode != $past(power_mode) |->
      $past(sleep_exec) || $past(wake_request) || $past(wakeup_irq))
      else $error("Power mode changed without sleep or wake.");
   chk_sleep_refused: assert property (
      sleep_exec && low_power && !wake_request && !wakeup_irq
      |=> $stable(power_mode)) else $error("Sleep taken in low power mode.");
   chk_wake_exit: assert property (
      wake_request && power_mode inside {PMWC_SLEEP, PMWC_STANDBY}
      |=> power_mode inside {PMWC_HIGH_SPEED, PMWC_MEDIUM_SPEED})
      else $error("Wake from sleep or standby did not reach active mode.");
   chk_cfg_by_write: assert property (
      !$stable({subactive_divide, noise_filter_divide, watchdog_standby})
      |-> $past(avs_write)) else $error("Control output changed unwritten.");
   cover property (sleep_exec && power_mode == PMWC_HIGH_SPEED);
   cover property ($rose(direct_transition_irq));
   cover property ($rose(wakeup_irq));
endmodule
bind pmwc_top pmwc_chk u_pmwc_chk (
   .clk_sys, .rst, .avs_address, .avs_read, .avs_write, .avs_readdata,
   .avs_waitrequest, .sleep_exec, .wake_request, .timer_a_overflow,
   .wakeup_pin, .power_mode, .subactive_divide, .noise_filter_divide,
   .watchdog_standby, .timer_a_irq, .direct_transition_irq, .wakeup_irq
);

// ===== tb/pmwc_top_tb_top.sv
/*
  Self-checking bench of the power mode and wakeup control block.
  Assumes the bound checker and a design answering with one wait cycle.
*/
module pmwc_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import pmwc_pkg::*;
   logic clk_sys, rst, avs_read, avs_write, avs_waitrequest;
   logic sleep_exec, wake_request, timer_a_overflow, timer_a_clock_source_bit;
   logic [9:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0] avs_byteenable, subactive_divide;
   logic [7:0] wakeup_pin, noise_filter_divide;
   logic [2:0] power_mode;
   logic cpu_on_subclock, external_interrupt_four_rising_edge, timer_a_irq, wakeup_irq;
   logic direct_transition_irq, secondary_serial_standby;
   logic decoder_serial_standby, watchdog_standby;
   int n_mismatch, checked;
   logic [7:0] ridx [9] = '{8'hF0, 8'hF1, 8'hF2, 8'hF3, 8'hF4, 8'hF5,
      8'hF9, 8'hFA, 8'hFB};
   logic [7:0] rval [9] = '{8'h07, 8'hF0, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'hFF, 8'hFF};
   pmwc_top u_pmwc_top (.clk_sys, .rst, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
      .sleep_exec, .wake_request, .timer_a_overflow, .timer_a_clock_source_bit,
      .wakeup_pin, .power_mode, .cpu_on_subclock, .subactive_divide,
      .noise_filter_divide, .external_interrupt_four_rising_edge, .timer_a_irq,
      .direct_transition_irq, .wakeup_irq, .secondary_serial_standby,
      .decoder_serial_standby, .watchdog_standby);
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   task automatic report_and_stop();
      $display("checked %0d n_mismatch %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // The wait is read just after each rising edge, where it still shows the
   // value that edge saw; read data are taken at that same edge.
   task automatic bus(input logic w, input logic [7:0] idx,
      input logic [7:0] d, output logic [31:0] q);
      int n;
      n = 0;
      avs_address <= {idx, 2'b00};
      avs_writedata <= {24'h0, d};
      avs_read <= !w;
      avs_write <= w;
      do begin
         @(posedge clk_sys);
         n++;
         if (n > 20) begin
            n_mismatch++;
            report_and_stop();
         end
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      // One idle edge keeps the next request off the edge of this release.
      @(posedge clk_sys);
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, idx, d, q);
   endtask
   task automatic rc(input logic [7:0] idx, input logic [7:0] exp);
      logic [31:0] q;
      bus(1'b0, idx, 8'h00, q);
      chk(q, {24'h0, exp});
   endtask
   task automatic ev(input logic slp, input logic [2:0] m);
      sleep_exec <= slp;
      wake_request <= !slp;
      @(posedge clk_sys);
      sleep_exec <= 1'b0;
      wake_request <= 1'b0;
      @(posedge clk_sys);
      chk(32'(power_mode), 32'(m));
   endtask
   initial begin
      {avs_read, avs_write, sleep_exec, wake_request} = 4'h0;
      {timer_a_overflow, timer_a_clock_source_bit} = 2'b00;
      avs_address = 10'h000;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hF;
      wakeup_pin = 8'h00;
      rst = 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      chk(32'(power_mode), 32'(PMWC_HIGH_SPEED));
      chk(32'(noise_filter_divide), 32'(NOISE_DIV_FAST));
      chk(32'({secondary_serial_standby, decoder_serial_standby,
         watchdog_standby}), 32'h0);
      for (int i = 0; i < 9; i++) begin
         rc(ridx[i], rval[i]);
      end
      rc(8'h00, 8'h00);
      $display("test reset values done");
      wr(8'hF0, 8'h00);
      rc(8'hF0, 8'h04);
      wr(8'hFB, 8'h00);
      rc(8'hFB, 8'hFB);
      chk(32'(watchdog_standby), 32'h1);
      wr(8'hFA, 8'h00);
      rc(8'hFA, 8'hFC);
      chk(32'({secondary_serial_standby, decoder_serial_standby}),
         32'h3);
      wr(8'hFA, 8'hFF);
      wr(8'hFB, 8'hFF);
      chk(32'({secondary_serial_standby, decoder_serial_standby,
         watchdog_standby}), 32'h0);
      // A write with the low byte lane off must leave the register alone.
      avs_byteenable <= 4'hE;
      wr(8'hF1, 8'h1F);
      avs_byteenable <= 4'hF;
      rc(8'hF1, 8'hF0);
      wr(8'h00, 8'hFF);
      rc(8'h00, 8'h00);
      for (int v = 0; v < 4; v++) begin
         wr(8'hF1, 8'(v));
         chk(32'(subactive_divide), v > 1 ? 32'(SUB_DIV_TWO) :
            v == 1 ? 32'(SUB_DIV_FOUR) : 32'(SUB_DIV_EIGHT));
      end
      chk(32'(noise_filter_divide), 32'(NOISE_DIV_SLOW));
      wr(8'hF1, 8'h10);
      chk(32'(noise_filter_divide), 32'(NOISE_DIV_FAST));
      wr(8'hF2, 8'h10);
      chk(32'(external_interrupt_four_rising_edge), 32'h1);
      wr(8'hF2, 8'h00);
      chk(32'(external_interrupt_four_rising_edge), 32'h0);
      $display("test register fields done");
      wr(8'hF1, 8'h00);
      ev(1'b1, PMWC_SLEEP);
      ev(1'b1, PMWC_SLEEP);
      ev(1'b0, PMWC_HIGH_SPEED);
      wr(8'hF1, 8'h04);
      ev(1'b1, PMWC_SLEEP);
      ev(1'b0, PMWC_MEDIUM_SPEED);
      wr(8'hF1, 8'h00);
      wr(8'hF0, 8'h80);
      ev(1'b1, PMWC_STANDBY);
      ev(1'b0, PMWC_HIGH_SPEED);
      timer_a_clock_source_bit <= 1'b1;
      ev(1'b1, PMWC_WATCH);
      ev(1'b0, PMWC_HIGH_SPEED);
      wr(8'hF0, 8'h00);
      wr(8'hF1, 8'h0C);
      ev(1'b1, PMWC_MEDIUM_SPEED);
      rc(8'hF4, 8'h02);
      chk(32'(direct_transition_irq), 32'h0);
      wr(8'hF3, 8'h02);
      chk(32'(direct_transition_irq), 32'h1);
      wr(8'hF4, 8'h00);
      chk(32'(direct_transition_irq), 32'h0);
      wr(8'hF1, 8'h08);
      ev(1'b1, PMWC_HIGH_SPEED);
      wr(8'hF0, 8'h88);
      chk(32'(cpu_on_subclock), 32'h1);
      ev(1'b1, PMWC_SUBACTIVE);
      wr(8'hF1, 8'h00);
      wr(8'hF0, 8'h08);
      ev(1'b1, PMWC_SUBSLEEP);
      ev(1'b0, PMWC_SUBACTIVE);
      wr(8'hF0, 8'h88);
      ev(1'b1, PMWC_WATCH);
      ev(1'b0, PMWC_SUBACTIVE);
      wr(8'hF0, 8'h80);
      wr(8'hF1, 8'h0C);
      ev(1'b1, PMWC_MEDIUM_SPEED);
      chk(32'(cpu_on_subclock), 32'h0);
      wr(8'hF4, 8'h00);
      wr(8'hF3, 8'h00);
      $display("test power modes done");
      timer_a_overflow <= 1'b1;
      @(posedge clk_sys);
      timer_a_overflow <= 1'b0;
      @(posedge clk_sys);
      rc(8'hF4, 8'h01);
      chk(32'(timer_a_irq), 32'h0);
      wr(8'hF3, 8'h01);
      chk(32'(timer_a_irq), 32'h1);
      wr(8'hF4, 8'hFF);
      rc(8'hF4, 8'h01);
      wr(8'hF4, 8'h00);
      rc(8'hF4, 8'h00);
      chk(32'(timer_a_irq), 32'h0);
      $display("test timer flag done");
      // Pin 1 toggles too but is not a wakeup input, so its flag stays 0.
      wr(8'hF5, 8'h01);
      wakeup_pin <= 8'h03;
      repeat (5) @(posedge clk_sys);
      rc(8'hF9, 8'h01);
      chk(32'(wakeup_irq), 32'h1);
      wakeup_pin <= 8'h00;
      repeat (5) @(posedge clk_sys);
      wr(8'hF9, 8'h00);
      rc(8'hF9, 8'h00);
      chk(32'(wakeup_irq), 32'h0);
      $display("test wakeup flags done");
      report_and_stop();
   end
endmodule
